// ==== bsc_defines.svh ====
// Constants for the backup status and control register logic
`ifndef BSC_DEFINES_SVH
`define BSC_DEFINES_SVH

// -----------------------------------------------------------------
// Command codes
// -----------------------------------------------------------------
`define BSC_CMD_CTRL     8'h12
`define BSC_CMD_STAT     8'h3d

// -----------------------------------------------------------------
// Reset values, fixed status bits, strap wait and synchroniser width
// -----------------------------------------------------------------
`define BSC_PIN_EN_RST   3'h0
`define BSC_PIN_LVL_RST  3'h0
`define BSC_STAT_ONE     1'h1
`define BSC_STAT_ZERO2   2'h0
`define BSC_STRAP_WAIT   2'h2
`define BSC_SYNC_W       14

`endif

// ==== bsc_host.sv ====
// Host model that issues register commands to the block
`timescale 1ns/100ps
`include "bsc_defines.svh"
`default_nettype none

module bsc_host
   import bsc_pkg::*;
(
   input  wire logic        clk_i,
   output var  bsc_cmd_t    cmd_o,
   input  wire logic        rd_valid_i,
   input  wire logic        rd_err_i,
   input  wire logic [15:0] rd_data_i
);
   initial cmd_o = '0;

   // ---------------------------------------------------------------
   // Bus cycles
   // ---------------------------------------------------------------
   // Control is commanded by a whole-word write only; enables go with routes
   task automatic wr(input logic [15:0] d);
      @(posedge clk_i);
      #1 cmd_o = '{wr: 1'b1, rd: 1'b0, code: `BSC_CMD_CTRL, data: d};
      @(posedge clk_i);
      // Released data is inverted so a stale word is never mistaken for live
      #1 cmd_o = '{wr: 1'b0, rd: 1'b0, code: 8'h00, data: ~d};
   endtask

   task automatic rd(input logic [7:0] c, output logic [15:0] d, output logic e);
      @(posedge clk_i);
      #1 cmd_o = '{wr: 1'b0, rd: 1'b1, code: c, data: cmd_o.data};
      @(posedge clk_i);
      #1 cmd_o.rd = 1'b0;
      for (int i = 0; i < 4 && rd_valid_i !== 1'b1; i++) begin
         @(posedge clk_i);
         #1;
      end
      d = (rd_valid_i === 1'b1) ? rd_data_i : 16'hxxxx;
      e = rd_err_i;
   endtask
endmodule

`default_nettype wire

// ==== bsc_pkg.sv ====
// Types for the backup status and control register logic
package bsc_pkg;

   // --------------------------------------------------------------
   // Status word, bit 15 first; pin index 2 is io_pin_1
   // --------------------------------------------------------------
   typedef struct packed {
      logic       calib_running;
      logic       calib_done;
      logic       backup_active;
      logic [1:0] rsvd_hi;
      logic [2:0] pin_sense;
      logic       rsvd_one;
      logic       charge_fault;
      logic       backup_fault;
      logic       calib_fault;
      logic       charge_phase_lo;
      logic       charge_phase_hi;
      logic       rsvd_lo;
      logic       charge_hold_flag;
   } bsc_status_t;

   // --------------------------------------------------------------
   // Control word, bit 15 first; pin index 2 is io_pin_1
   // --------------------------------------------------------------
   typedef struct packed {
      logic       calib_go;
      logic       calib_clear;
      logic [2:0] pin_en;
      logic [2:0] pin_level;
      logic       rsvd;
      logic       pin1_charging_route;
      logic       pin2_fault_route;
      logic       pin3_calibdone_route;
      logic       charge_clear_cmd;
      logic       full_reinit_cmd;
      logic       fault_clear_cmd;
      logic       charge_hold_ctl;
   } bsc_ctrl_t;

   // --------------------------------------------------------------
   // Command from the bus protocol engine
   // --------------------------------------------------------------
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [7:0]  code;
      logic [15:0] data;
   } bsc_cmd_t;

   typedef enum logic {
      BSC_CAL_IDLE,
      BSC_CAL_RUN
   } bsc_cal_state_t;

endpackage

// ==== bsc_regs.sv ====
// Backup status and control register logic
//
// Overview of operation
// - Set backup fault on low cell voltage
// - Fault clears by shutdown or commands with supply
// - Early calibration end sets calibration fault
// - Charge phase reads off/pre/bulk/top-off
// - Hold flag mirrors charge hold control bit
// - Control word is write-only, never read back
// - Calibration go starts calibration, self-clears
// - Calibration clear clears flags, stops calibration
// - Enable bit drives pin; strap sets default after shutdown or reinit
// - Level bit drives pin unless routed, default low
// - Pin 1 routed shows inverted charging active
// - Pin 2 routed shows inverted backup fault
// - Pin 3 routed shows inverted calibration done
// - Routed signal needs pin enable set
// - Charge clear resets charger, keeps control
// - Full reinit restores all power-on defaults
// - Fault clear command clears backup fault
// - Hold stops current, pauses timers, keeps values
// - Power or battery return clears hold
// - Pin sense always shows pin level
// - Calibration done set at finish until cleared
`timescale 1ns/100ps
`include "bsc_defines.svh"
`default_nettype none

module bsc_regs
   import bsc_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        resetn_i,
   input  wire bsc_cmd_t    cmd_i,
   output var  logic        rd_valid_o,
   output var  logic        rd_err_o,
   output var  logic [15:0] rd_data_o,
   input  wire logic        cell_low_i,
   input  wire logic        bat_ok_i,
   input  wire logic        supply_ok_i,
   input  wire logic        shutdown_pin_i,
   input  wire logic        addr_select_mid_i,
   input  wire logic [1:0]  charge_phase_i,
   input  wire logic        charge_fault_i,
   input  wire logic        backup_active_i,
   input  wire logic        power_in_i,
   input  wire logic        bat_present_i,
   input  wire logic        calib_finish_i,
   input  wire logic        calib_abort_i,
   input  wire logic [2:0]  pin_i,
   output var  logic [2:0]  pin_o,
   output var  logic [2:0]  pin_oe_o,
   output var  logic        calib_start_o,
   output var  logic        calib_run_o,
   output var  logic        charge_clear_o,
   output var  logic        charge_hold_o,
   output var  logic        chip_reinit_o
);

   // --------------------------------------------------------------
   // Input synchronisers
   // --------------------------------------------------------------
   // Every pin and analog comparator passes two flops; the third
   // stage only feeds the edge detectors below.
   logic [`BSC_SYNC_W-1:0] async_w;
   logic [`BSC_SYNC_W-1:0] sync1_q;
   logic [`BSC_SYNC_W-1:0] sync2_q;
   logic [1:0]             edge3_q;

   assign async_w = {cell_low_i, bat_ok_i, supply_ok_i,
                     shutdown_pin_i, addr_select_mid_i,
                     charge_phase_i, charge_fault_i,
                     backup_active_i, power_in_i,
                     bat_present_i, pin_i};

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         sync1_q <= '0;
         sync2_q <= '0;
      end else begin
         sync1_q <= async_w;
         sync2_q <= sync1_q;
      end
   end

   logic       cell_low_s;
   logic       bat_ok_s;
   logic       supply_ok_s;
   logic       shutdown_pin_s;
   logic       strap_s;
   logic [1:0] phase_s;
   logic       chg_fault_s;
   logic       bkup_act_s;
   logic       pwr_in_s;
   logic       bat_in_s;
   logic [2:0] pin_s;

   assign {cell_low_s, bat_ok_s, supply_ok_s, shutdown_pin_s, strap_s,
           phase_s, chg_fault_s, bkup_act_s, pwr_in_s,
           bat_in_s, pin_s} = sync2_q;

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         edge3_q <= 2'h0;
      end else begin
         edge3_q <= {pwr_in_s, bat_in_s};
      end
   end

   logic power_return;
   logic bat_return;

   assign power_return = pwr_in_s & ~edge3_q[1];
   assign bat_return   = bat_in_s & ~edge3_q[0];

   // --------------------------------------------------------------
   // Command decode
   // --------------------------------------------------------------
   logic      ctl_wr;
   bsc_ctrl_t ctl_w;

   assign ctl_wr = cmd_i.wr && (cmd_i.code == `BSC_CMD_CTRL);
   assign ctl_w  = bsc_ctrl_t'(cmd_i.data);

   function automatic logic cmd_one(input logic wr_en,
                                    input logic bit_v);
      cmd_one = wr_en & bit_v;
   endfunction

   // --------------------------------------------------------------
   // Whole-chip reinit
   // --------------------------------------------------------------
   // The reinit command is taken one cycle late so that it is a
   // clean synchronous reset for the calibration, pin configuration and hold registers below.
   logic reinit_q;
   logic srst;

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         reinit_q <= 1'b0;
      end else begin
         reinit_q <= cmd_one(ctl_wr, ctl_w.full_reinit_cmd);
      end
   end

   assign srst = shutdown_pin_s | reinit_q;

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         chip_reinit_o <= 1'b0;
      end else begin
         chip_reinit_o <= reinit_q;
      end
   end

   // --------------------------------------------------------------
   // Backup fault
   // --------------------------------------------------------------
   // A clear asked for while the output supply is still absent is
   // held until the supply returns, then applied once.
   logic backup_fault_q;
   logic flt_clr_pend_q;

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         flt_clr_pend_q <= 1'b0;
      end else if (shutdown_pin_s || supply_ok_s) begin
         flt_clr_pend_q <= 1'b0;
      end else if (cmd_one(ctl_wr, ctl_w.fault_clear_cmd) ||
                   cmd_one(ctl_wr, ctl_w.full_reinit_cmd)) begin
         flt_clr_pend_q <= 1'b1;
      end
   end

   logic flt_clr;

   assign flt_clr = supply_ok_s &&
                    (cmd_one(ctl_wr, ctl_w.fault_clear_cmd) ||
                     cmd_one(ctl_wr, ctl_w.full_reinit_cmd) ||
                     flt_clr_pend_q);

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         backup_fault_q <= 1'b0;
      end else if (!bat_ok_s) begin
         backup_fault_q <= 1'b0;
      end else if (cell_low_s) begin
         backup_fault_q <= 1'b1;
      end else if (shutdown_pin_s || flt_clr) begin
         backup_fault_q <= 1'b0;
      end
   end

   // --------------------------------------------------------------
   // Calibration
   // --------------------------------------------------------------
   bsc_cal_state_t cal_state_q;
   logic           calib_done_q;
   logic           calib_fault_q;
   logic           cal_clr;

   assign cal_clr = cmd_one(ctl_wr, ctl_w.calib_clear);

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cal_state_q <= BSC_CAL_IDLE;
      end else if (srst) begin
         cal_state_q <= BSC_CAL_IDLE;
      end else begin
         case (cal_state_q)
            BSC_CAL_IDLE: begin
               if (cmd_one(ctl_wr, ctl_w.calib_go) && !cal_clr) begin
                  cal_state_q <= BSC_CAL_RUN;
               end
            end
            BSC_CAL_RUN: begin
               if (cal_clr || calib_finish_i || calib_abort_i) begin
                  cal_state_q <= BSC_CAL_IDLE;
               end
            end
            default: begin
               cal_state_q <= BSC_CAL_IDLE;
            end
         endcase
      end
   end

   logic cal_running;

   assign cal_running = (cal_state_q == BSC_CAL_RUN);

   // Finish and abort only count while a calibration is running;
   // a set in the same cycle as a clear wins.
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         calib_done_q <= 1'b0;
      end else if (srst) begin
         calib_done_q <= 1'b0;
      end else if (cal_running && calib_finish_i) begin
         calib_done_q <= 1'b1;
      end else if (cal_clr) begin
         calib_done_q <= 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         calib_fault_q <= 1'b0;
      end else if (srst) begin
         calib_fault_q <= 1'b0;
      end else if (cal_running && calib_abort_i) begin
         calib_fault_q <= 1'b1;
      end else if (cal_clr) begin
         calib_fault_q <= 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         calib_start_o <= 1'b0;
         calib_run_o   <= 1'b0;
      end else begin
         calib_start_o <= !srst && !cal_running && !cal_clr &&
                          cmd_one(ctl_wr, ctl_w.calib_go);
         calib_run_o   <= cal_running;
      end
   end

   // --------------------------------------------------------------
   // Pin configuration
   // --------------------------------------------------------------
   // The strap is caught on the second clock after reset, while the synchroniser still holds zero,
   // and again after every shutdown or reinit.
   logic [1:0] strap_cnt_q;
   logic [2:0] pin_en_q;
   logic [2:0] pin_level_q;
   logic [2:0] pin_route_q;

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         strap_cnt_q <= 2'h0;
      end else if (srst) begin
         strap_cnt_q <= 2'h0;
      end else if (strap_cnt_q != `BSC_STRAP_WAIT) begin
         strap_cnt_q <= strap_cnt_q + 2'h1;
      end
   end

   logic strap_load;

   assign strap_load = (strap_cnt_q == (`BSC_STRAP_WAIT - 2'h1));

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pin_en_q <= `BSC_PIN_EN_RST;
      end else if (srst) begin
         pin_en_q <= `BSC_PIN_EN_RST;
      end else if (strap_load) begin
         pin_en_q <= {3{strap_s}};
      end else if (ctl_wr) begin
         pin_en_q <= ctl_w.pin_en;
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pin_level_q <= `BSC_PIN_LVL_RST;
         pin_route_q <= 3'h0;
      end else if (srst) begin
         pin_level_q <= `BSC_PIN_LVL_RST;
         pin_route_q <= 3'h0;
      end else if (ctl_wr) begin
         pin_level_q <= ctl_w.pin_level;
         pin_route_q <= {ctl_w.pin1_charging_route,
                         ctl_w.pin2_fault_route,
                         ctl_w.pin3_calibdone_route};
      end
   end

   logic       charging_active;
   logic [2:0] pin_val;

   assign charging_active = phase_s[1] | phase_s[0];

   always_comb begin
      pin_val = pin_level_q;
      if (pin_route_q[2]) begin
         pin_val[2] = ~charging_active;
      end
      if (pin_route_q[1]) begin
         pin_val[1] = ~backup_fault_q;
      end
      if (pin_route_q[0]) begin
         pin_val[0] = ~calib_done_q;
      end
   end

   // Value and enable are registered together, so a routed
   // signal only leaves the chip through an enabled pin.
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pin_o    <= 3'h0;
         pin_oe_o <= 3'h0;
      end else begin
         pin_o    <= pin_val;
         pin_oe_o <= pin_en_q;
      end
   end

   // --------------------------------------------------------------
   // Charger commands and hold
   // --------------------------------------------------------------
   logic charge_hold_q;

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         charge_clear_o <= 1'b0;
      end else begin
         charge_clear_o <= !srst &&
                           cmd_one(ctl_wr, ctl_w.charge_clear_cmd);
      end
   end

   // A returning supply or battery beats a write in the same cycle,
   // since the hold must not outlive the event that ends it.
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         charge_hold_q <= 1'b0;
      end else if (srst || power_return || bat_return) begin
         charge_hold_q <= 1'b0;
      end else if (ctl_wr) begin
         charge_hold_q <= ctl_w.charge_hold_ctl;
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         charge_hold_o <= 1'b0;
      end else begin
         charge_hold_o <= charge_hold_q;
      end
   end

   // --------------------------------------------------------------
   // Status read
   // --------------------------------------------------------------
   bsc_status_t stat_w;

   always_comb begin
      stat_w                  = '0;
      stat_w.calib_running    = cal_running;
      stat_w.calib_done       = calib_done_q;
      stat_w.backup_active    = bkup_act_s;
      stat_w.rsvd_hi          = `BSC_STAT_ZERO2;
      stat_w.pin_sense        = pin_s;
      stat_w.rsvd_one         = `BSC_STAT_ONE;
      stat_w.charge_fault     = chg_fault_s;
      stat_w.backup_fault     = backup_fault_q;
      stat_w.calib_fault      = calib_fault_q;
      stat_w.charge_phase_lo  = phase_s[0];
      stat_w.charge_phase_hi  = phase_s[1];
      stat_w.charge_hold_flag = charge_hold_q;
   end

   // Only the status code answers with data; the control code and
   // anything unknown answer zero with the error flag.
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rd_valid_o <= 1'b0;
         rd_err_o   <= 1'b0;
         rd_data_o  <= 16'h0000;
      end else if (cmd_i.rd) begin
         rd_valid_o <= 1'b1;
         if (cmd_i.code == `BSC_CMD_STAT) begin
            rd_err_o  <= 1'b0;
            rd_data_o <= stat_w;
         end else begin
            rd_err_o  <= 1'b1;
            rd_data_o <= 16'h0000;
         end
      end else begin
         rd_valid_o <= 1'b0;
         rd_err_o   <= 1'b0;
      end
   end

endmodule

`default_nettype wire

// ==== bsc_regs_assertions.sv ====
// Checker for the backup status and control register logic
`timescale 1ns/100ps
`include "bsc_defines.svh"
`default_nettype none

module bsc_regs_checker
   import bsc_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        resetn_i,
   input  wire bsc_cmd_t    cmd_i,
   input  wire logic        rd_valid_o,
   input  wire logic        rd_err_o,
   input  wire logic [15:0] rd_data_o,
   input  wire logic [2:0]  pin_oe_o,
   input  wire logic        calib_start_o,
   input  wire logic        calib_run_o,
   input  wire logic        charge_clear_o,
   input  wire logic        charge_hold_o,
   input  wire logic        chip_reinit_o
);
   // ---------------------------------------------------------------
   // Properties
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);

   wire logic ctl_w = cmd_i.wr && (cmd_i.code == `BSC_CMD_CTRL);

   read_answer_a: assert property (cmd_i.rd |=> rd_valid_o)
      else $error("read not answered");
   wo_read_a: assert property (cmd_i.rd && cmd_i.code == `BSC_CMD_CTRL
      |=> rd_err_o && rd_data_o == 16'h0000) else $error("control word read back");
   stat_read_a: assert property (cmd_i.rd && cmd_i.code == `BSC_CMD_STAT
      |=> !rd_err_o) else $error("status read refused");
   calib_go_a: assert property (ctl_w && cmd_i.data[15] && !cmd_i.data[14]
      && !calib_run_o |=> calib_start_o) else $error("calibration not started");
   start_pulse_a: assert property (calib_start_o |=> calib_run_o && !calib_start_o)
      else $error("start pulse wrong");
   clear_stop_a: assert property (ctl_w && cmd_i.data[14] |=> ##1 !calib_run_o)
      else $error("calibration not stopped");
   charge_clear_a: assert property (ctl_w && cmd_i.data[3]
      |=> charge_clear_o ##1 !charge_clear_o) else $error("charge clear pulse wrong");
   clear_cause_a: assert property (charge_clear_o |-> $past(ctl_w) && $past(cmd_i.data[3]))
      else $error("charge clear without command");
   reinit_a: assert property (ctl_w && cmd_i.data[2] |=> ##1 chip_reinit_o)
      else $error("reinit not issued");
   reinit_cfg_a: assert property (chip_reinit_o |=> pin_oe_o == 3'h0)
      else $error("pin enables kept over reinit");
   hold_set_a: assert property (ctl_w && cmd_i.data[0] |=> ##1 charge_hold_o)
      else $error("hold not applied");

   cover property (calib_start_o);
   cover property (chip_reinit_o);
   cover property (rd_valid_o && rd_err_o);
endmodule

bind bsc_regs bsc_regs_checker u_bsc_regs_checker (.clk_i(clk_i), .resetn_i(resetn_i),
   .cmd_i(cmd_i), .rd_valid_o(rd_valid_o), .rd_err_o(rd_err_o), .rd_data_o(rd_data_o),
   .pin_oe_o(pin_oe_o), .calib_start_o(calib_start_o), .calib_run_o(calib_run_o),
   .charge_clear_o(charge_clear_o), .charge_hold_o(charge_hold_o),
   .chip_reinit_o(chip_reinit_o));

`default_nettype wire

// ==== test_backup_status_control_regs.sv ====
// Self-checking bench for the backup status and control register logic
`timescale 1ns/100ps
`include "bsc_defines.svh"
`default_nettype none

module test_backup_status_control_regs
   import bsc_pkg::*;
;
   // ---------------------------------------------------------------
   // Signals
   // ---------------------------------------------------------------
   logic        clk_i, resetn_i, cell_low, bat_ok, supply_ok, shut, strap, chg_flt;
   logic        bk_act, pwr_in, bat_in, cal_fin, cal_abt;
   logic [1:0]  phase;
   bsc_cmd_t    cmd;
   logic        rd_valid, rd_err, cal_start, cal_run, chg_clr, hold, reinit;
   logic [15:0] rd_data;
   logic [2:0]  pin_out, pin_oe;
   wire  [2:0]  pin_in;
   int          n_fail = 0, samples_checked = 0, cyc = 0;

   // Released pins sit at their pull-up level
   assign pin_in = (pin_out & pin_oe) | ~pin_oe;

   always #2 clk_i = ~clk_i;

   bsc_regs u_bsc_regs (.clk_i(clk_i), .resetn_i(resetn_i), .cmd_i(cmd),
      .rd_valid_o(rd_valid), .rd_err_o(rd_err), .rd_data_o(rd_data),
      .cell_low_i(cell_low), .bat_ok_i(bat_ok), .supply_ok_i(supply_ok),
      .shutdown_pin_i(shut), .addr_select_mid_i(strap), .charge_phase_i(phase),
      .charge_fault_i(chg_flt), .backup_active_i(bk_act), .power_in_i(pwr_in),
      .bat_present_i(bat_in), .calib_finish_i(cal_fin), .calib_abort_i(cal_abt),
      .pin_i(pin_in), .pin_o(pin_out), .pin_oe_o(pin_oe), .calib_start_o(cal_start),
      .calib_run_o(cal_run), .charge_clear_o(chg_clr), .charge_hold_o(hold),
      .chip_reinit_o(reinit));

   bsc_host u_bsc_host (.clk_i(clk_i), .cmd_o(cmd), .rd_valid_i(rd_valid),
      .rd_err_i(rd_err), .rd_data_i(rd_data));

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   task automatic end_sim();
      if (n_fail == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      samples_checked++;
      if (g !== e) begin
         n_fail++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask

   task automatic chb(input string nm, input logic e, input logic g);
      chk(nm, {15'h0, e}, {15'h0, g});
   endtask

   // Fixed waits cover the two-flop input synchronisers
   task automatic tk(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask

   task automatic rs(output logic [15:0] s);
      logic e;
      u_bsc_host.rd(`BSC_CMD_STAT, s, e);
   endtask

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_reset();
      logic [15:0] s;
      logic        e;
      rs(s);
      chk("oe", 16'h0, {13'h0, pin_oe});
      chk("lvl", 16'h0, {13'h0, pin_out});
      chk("sense", 16'h0700, s & 16'h0700);
      chb("hold", 1'b0, s[0]);
      u_bsc_host.rd(`BSC_CMD_CTRL, s, e);
      chk("ctl_rd", 16'h0, s);
      chb("ctl_err", 1'b1, e);
   endtask

   task automatic t_phase();
      logic [15:0] s;
      u_bsc_host.wr(16'h2040);
      for (int p = 0; p < 4; p++) begin
         phase = p[1:0];
         tk(4);
         rs(s);
         chk("phase", {14'h0, p[1:0]}, {14'h0, s[2], s[3]});
         chb("pin1", ~|p[1:0], pin_out[2]);
      end
      phase = 2'h0;
      u_bsc_host.wr(16'h0040);
      tk(3);
      chk("pin1_oe", 16'h0, {13'h0, pin_oe});
   endtask

   task automatic t_fault();
      logic [15:0] s;
      u_bsc_host.wr(16'h1020);
      cell_low = 1'b1;
      tk(4);
      cell_low = 1'b0;
      tk(4);
      rs(s);
      chb("bkfault", 1'b1, s[5]);
      chb("pin2", 1'b0, pin_out[1]);
      u_bsc_host.wr(16'h1020);
      rs(s);
      chb("noclr", 1'b1, s[5]);
      supply_ok = 1'b0;
      tk(4);
      u_bsc_host.wr(16'h1022);
      tk(2);
      rs(s);
      chb("pending", 1'b1, s[5]);
      supply_ok = 1'b1;
      tk(6);
      rs(s);
      chb("cleared", 1'b0, s[5]);
      chb("pin2_hi", 1'b1, pin_out[1]);
   endtask

   task automatic t_calib();
      logic [15:0] s;
      u_bsc_host.wr(16'h8000);
      rs(s);
      chb("run", 1'b1, s[15]);
      cal_fin = 1'b1;
      tk(1);
      cal_fin = 1'b0;
      tk(2);
      rs(s);
      chb("done", 1'b1, s[14]);
      chb("run_end", 1'b0, s[15]);
      u_bsc_host.wr(16'h0810);
      tk(2);
      chb("pin3", 1'b0, pin_out[0]);
      u_bsc_host.wr(16'h4810);
      tk(2);
      rs(s);
      chb("done_clr", 1'b0, s[14]);
      chb("pin3_hi", 1'b1, pin_out[0]);
      u_bsc_host.wr(16'h8000);
      cal_abt = 1'b1;
      tk(1);
      cal_abt = 1'b0;
      tk(2);
      rs(s);
      chb("calfault", 1'b1, s[4]);
      chb("nodone", 1'b0, s[14]);
      u_bsc_host.wr(16'h4000);
      rs(s);
      chb("cf_clr", 1'b0, s[4]);
      u_bsc_host.wr(16'h8000);
      u_bsc_host.wr(16'h4000);
      rs(s);
      chb("stop", 1'b0, s[15]);
   endtask

   task automatic t_hold();
      logic [15:0] s;
      u_bsc_host.wr(16'h0001);
      tk(2);
      rs(s);
      chb("hold_st", 1'b1, s[0]);
      chb("hold_o", 1'b1, hold);
      pwr_in = 1'b0;
      tk(4);
      pwr_in = 1'b1;
      tk(4);
      rs(s);
      chb("hold_pwr", 1'b0, s[0]);
      u_bsc_host.wr(16'h0001);
      tk(2);
      bat_in = 1'b0;
      tk(4);
      bat_in = 1'b1;
      tk(4);
      chb("hold_bat", 1'b0, hold);
   endtask

   task automatic t_level();
      logic [15:0] s;
      u_bsc_host.wr(16'h3d00);
      tk(2);
      chk("lvl", 16'h0005, {13'h0, pin_out});
      chk("en", 16'h0007, {13'h0, pin_oe});
      rs(s);
      chk("sense_lo", 16'h0500, s & 16'h0700);
      u_bsc_host.wr(16'h3d08);
      chb("chg_clr", 1'b1, chg_clr);
      tk(2);
      chk("keep", 16'h0005, {13'h0, pin_out});
      u_bsc_host.wr(16'h3d04);
      tk(1);
      chb("reinit", 1'b1, reinit);
      tk(2);
      chk("oe_def", 16'h0, {13'h0, pin_oe});
   endtask

   task automatic t_misc();
      logic [15:0] s;
      chg_flt = 1'b1;
      bk_act = 1'b1;
      cell_low = 1'b1;
      tk(4);
      cell_low = 1'b0;
      tk(4);
      rs(s);
      chk("flt_act", 16'h20e0, s & 16'h20e0);
      bat_ok = 1'b0;
      tk(4);
      rs(s);
      chb("bat_gone", 1'b0, s[5]);
      chg_flt = 1'b0;
      bk_act = 1'b0;
      bat_ok = 1'b1;
      tk(4);
   endtask

   task automatic t_strap();
      logic [15:0] s;
      cell_low = 1'b1;
      tk(4);
      cell_low = 1'b0;
      strap = 1'b1;
      shut = 1'b1;
      tk(4);
      shut = 1'b0;
      tk(8);
      chk("oe_strap", 16'h0007, {13'h0, pin_oe});
      rs(s);
      chb("shutdown_pin_clr", 1'b0, s[5]);
   endtask

   // ---------------------------------------------------------------
   // Run
   // ---------------------------------------------------------------
   // Whole sequence needs well under a thousand cycles
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         n_fail++;
         end_sim();
      end
   end

   initial begin
      {clk_i, resetn_i, cell_low, shut, strap, chg_flt, bk_act, cal_fin, cal_abt} = '0;
      {bat_ok, supply_ok, pwr_in, bat_in} = 4'hf;
      phase = 2'h0;
      repeat (20) @(posedge clk_i);
      #1 resetn_i = 1'b1;
      tk(1);
      t_reset();
      t_phase();
      t_fault();
      t_calib();
      t_hold();
      t_level();
      t_misc();
      t_strap();
      end_sim();
   end
endmodule

`default_nettype wire
